/* opmode_regs.vh */
`ifndef OPMODE_REGS_VH
`define OPMODE_REGS_VH

// Register indexes; the byte address is four times the index.
`define IDX_MODE_CTRL 8'h95
`define IDX_RESUME_EN 8'h99
`define IDX_STATUS 8'h9A

// Mode control fields.
`define MC_HIGH_OSC_STOP 1
`define MC_SLOW_CLOCK_SELECT 2
`define MC_SLEEP_REQUEST 3
`define MC_GREEN_REQUEST 4
`define MODE_CTRL_RESET 8'h00
`define RESUME_EN_RESET 8'h00

// Status fields.
`define ST_WAKE_FLAG 0
`define ST_EXT_IRQ_FLAG 1
`define ST_MODE_LO 2
`define ST_MODE_HI 3
`define ST_SLOW_ACTIVE 4
`define ST_SWITCHING 5

// Values of the two-bit cpu mode field.
`define CPU_MODE_NORMAL 2'h0
`define CPU_MODE_SLEEP 2'h1
`define CPU_MODE_GREEN 2'h2
`define CPU_MODE_RESERVED 2'h3

// High-speed clock configurations.
`define HCLK_EXT_CRYSTAL 2'h0
`define HCLK_EXT_RC 2'h1
`define HCLK_FAST_INTERNAL_RC 2'h2
`define HCLK_FAST_RC_WITH_CRYSTAL32K 2'h3

// Warm-up after power-down, in high-speed oscillator clocks.
`define WARM_CRYSTAL_CLKS 2048
`define WARM_RC_CLKS 32

// Idle gap in clock cycles while the system clock source changes.
`define SWITCH_GAP_CYCLES 4

`endif

/* operating_mode_controller.v */
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "opmode_regs.vh"

module operating_mode_controller #(
   parameter [1:0] HIGH_CLK_TYPE = `HCLK_FAST_INTERNAL_RC,
   parameter [1:0] LOW_FCPU_SEL = 2'h0,
   parameter SLOW_RC_DIV = 16,
   parameter FAST_OSC_DIV = 1
) (
   // APB clock and reset.
   input wire pclk,
   input wire presetn,
   // APB slave.
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Wake sources.
   input wire [7:0] first_io_port,
   input wire [7:0] second_io_port,
   input wire ext_irq_pin,
   input wire timer_zero_overflow,
   // Oscillator and clock gating.
   output reg fast_osc_en,
   output reg slow_osc_en,
   output reg crystal32k_en,
   output reg fast_clk_gate,
   output reg slow_clk_gate,
   output reg cpu_clk_en,
   // Core and peripheral control.
   output reg cpu_run,
   output reg timer_enable,
   output reg irq_enable,
   output reg serial_enable,
   output reg ext_irq_req
);

   // ****************************************************************
   // Constants and state codes
   // ****************************************************************
   localparam [1:0] S_RUN = 2'h0;
   localparam [1:0] S_GREEN = 2'h1;
   localparam [1:0] S_PDOWN = 2'h2;
   localparam [1:0] S_WARM = 2'h3;
   localparam integer WARM_CYCLES_I = ((HIGH_CLK_TYPE == `HCLK_EXT_CRYSTAL) ?
      `WARM_CRYSTAL_CLKS : `WARM_RC_CLKS) * FAST_OSC_DIV;
   localparam integer SLOW_DIV_M1_I = SLOW_RC_DIV - 1;
   localparam integer GAP_M1_I = `SWITCH_GAP_CYCLES - 1;
   localparam [15:0] WARM_CYCLES = WARM_CYCLES_I[15:0];
   localparam [15:0] SLOW_DIV_M1 = SLOW_DIV_M1_I[15:0];
   localparam [2:0] GAP_M1 = GAP_M1_I[2:0];

   // Byte address decode of a register index.
   function hit;
      input [11:0] addr;
      input [7:0] idx;
      begin
         hit = (addr == {2'b00, idx, 2'b00});
      end
   endfunction

   // ****************************************************************
   // Registers and state
   // ****************************************************************
   reg [1:0] state_r;
   reg high_osc_stop_r, slow_clock_select_r, sleep_request_r, green_request_r;
   reg [7:0] second_port_resume_enable_r;
   reg wake_flag_r, ext_irq_flag_r;
   reg cur_slow_r, switching_r;
   reg [2:0] gap_cnt_r;
   reg [15:0] warm_cnt_r;
   reg [15:0] slow_cnt_r;
   reg [2:0] fcpu_cnt_r;
   reg [7:0] p0_s1_r, p0_s2_r, p0_old_r, p1_s1_r, p1_s2_r, p1_old_r;
   reg irq_s1_r, irq_s2_r, irq_old_r;
   reg [1:0] state_nxt;
   reg slow_tick, fcpu_tick, port_wake, irq_wake, any_wake;
   reg wr_mc, wr_en, wr_st, acc;
   wire [1:0] cpu_mode_field;

   assign cpu_mode_field = {green_request_r, sleep_request_r};

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {p0_old_r, p0_s2_r, p0_s1_r} <= 24'h000000;
         {p1_old_r, p1_s2_r, p1_s1_r} <= 24'h000000;
         {irq_old_r, irq_s2_r, irq_s1_r} <= 3'h0;
      end else begin
         {p0_old_r, p0_s2_r, p0_s1_r} <= {p0_s2_r, p0_s1_r, first_io_port};
         {p1_old_r, p1_s2_r, p1_s1_r} <= {p1_s2_r, p1_s1_r, second_io_port};
         {irq_old_r, irq_s2_r, irq_s1_r} <= {irq_s2_r, irq_s1_r, ext_irq_pin};
      end
   end

   // ****************************************************************
   // Wake detection and mode sequencing
   // ****************************************************************
   always @* begin
      port_wake = (|(p0_s2_r ^ p0_old_r)) |
         (|((p1_s2_r ^ p1_old_r) & second_port_resume_enable_r));
      irq_wake = irq_s2_r & ~irq_old_r;
      any_wake = port_wake | irq_wake;
      slow_tick = (slow_cnt_r == SLOW_DIV_M1);
      fcpu_tick = slow_tick && ((fcpu_cnt_r & ((3'h1 << LOW_FCPU_SEL) - 3'h1)) == 3'h0);
      acc = psel & penable & pready;
      wr_mc = acc & pwrite & hit(paddr, `IDX_MODE_CTRL);
      wr_en = acc & pwrite & hit(paddr, `IDX_RESUME_EN);
      wr_st = acc & pwrite & hit(paddr, `IDX_STATUS);
      state_nxt = state_r;
      case (state_r)
         S_RUN: begin
            if (sleep_request_r) begin
               state_nxt = S_PDOWN;
            end else if (green_request_r) begin
               state_nxt = S_GREEN;
            end else if (high_osc_stop_r && !cur_slow_r && !switching_r) begin
               state_nxt = S_PDOWN;
            end
         end
         S_GREEN: begin
            if (any_wake || timer_zero_overflow) begin
               state_nxt = S_RUN;
            end
         end
         S_PDOWN: begin
            if (any_wake) begin
               state_nxt = S_WARM;
            end
         end
         S_WARM: begin
            if (warm_cnt_r == 16'h0000) begin
               state_nxt = S_RUN;
            end
         end
         default: state_nxt = S_RUN;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= S_RUN;
         warm_cnt_r <= 16'h0000;
         high_osc_stop_r <= 1'b0;
         slow_clock_select_r <= 1'b0;
         sleep_request_r <= 1'b0;
         green_request_r <= 1'b0;
         second_port_resume_enable_r <= `RESUME_EN_RESET;
         wake_flag_r <= 1'b0;
         ext_irq_flag_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (state_r == S_PDOWN) begin
            warm_cnt_r <= WARM_CYCLES - 16'h0001;
         end else if (warm_cnt_r != 16'h0000) begin
            warm_cnt_r <= warm_cnt_r - 16'h0001;
         end
         if (wr_en) begin
            second_port_resume_enable_r <= pwdata[7:0];
         end
         if (wr_mc) begin
            high_osc_stop_r <= pwdata[`MC_HIGH_OSC_STOP];
            slow_clock_select_r <= pwdata[`MC_SLOW_CLOCK_SELECT];
            if (pwdata[`MC_GREEN_REQUEST:`MC_SLEEP_REQUEST] != `CPU_MODE_RESERVED) begin
               sleep_request_r <= pwdata[`MC_SLEEP_REQUEST];
               green_request_r <= pwdata[`MC_GREEN_REQUEST];
            end
         end
         if (state_r == S_PDOWN && any_wake) begin
            sleep_request_r <= 1'b0;
            slow_clock_select_r <= 1'b0;
            high_osc_stop_r <= 1'b0;
         end
         if (state_r == S_GREEN && state_nxt == S_RUN) begin
            green_request_r <= 1'b0;
         end
         if (wr_st && pwdata[`ST_WAKE_FLAG]) begin
            wake_flag_r <= 1'b0;
         end
         if (wr_st && pwdata[`ST_EXT_IRQ_FLAG]) begin
            ext_irq_flag_r <= 1'b0;
         end
         if ((state_r == S_PDOWN || state_r == S_GREEN) && state_nxt != state_r) begin
            if (irq_wake) begin
               ext_irq_flag_r <= 1'b1;
            end else begin
               wake_flag_r <= 1'b1;
            end
         end
      end
   end

   // ****************************************************************
   // Glitch-free clock source switch
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_slow_r <= 1'b0;
         switching_r <= 1'b0;
         gap_cnt_r <= 3'h0;
      end else if (state_r == S_WARM || state_r == S_PDOWN) begin
         cur_slow_r <= 1'b0;
         switching_r <= 1'b0;
      end else if (!switching_r && cur_slow_r != slow_clock_select_r) begin
         switching_r <= 1'b1;
         gap_cnt_r <= GAP_M1;
      end else if (switching_r) begin
         if (gap_cnt_r == 3'h0) begin
            switching_r <= 1'b0;
            cur_slow_r <= slow_clock_select_r;
         end else begin
            gap_cnt_r <= gap_cnt_r - 3'h1;
         end
      end
   end

   // ****************************************************************
   // Slow clock divider
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_cnt_r <= 16'h0000;
         fcpu_cnt_r <= 3'h0;
      end else if (state_r == S_PDOWN) begin
         slow_cnt_r <= 16'h0000;
      end else if (slow_tick) begin
         slow_cnt_r <= 16'h0000;
         fcpu_cnt_r <= fcpu_cnt_r + 3'h1;
      end else begin
         slow_cnt_r <= slow_cnt_r + 16'h0001;
      end
   end

   // ****************************************************************
   // Registered outputs
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_osc_en <= 1'b1;
         slow_osc_en <= 1'b1;
         crystal32k_en <= 1'b0;
         fast_clk_gate <= 1'b1;
         slow_clk_gate <= 1'b0;
         cpu_clk_en <= 1'b0;
         cpu_run <= 1'b1;
         timer_enable <= 1'b1;
         irq_enable <= 1'b1;
         serial_enable <= 1'b1;
         ext_irq_req <= 1'b0;
      end else begin
         fast_osc_en <= (state_r == S_WARM) ||
            ((state_r == S_RUN || state_r == S_GREEN) &&
            (!high_osc_stop_r || (!cur_slow_r && state_r == S_RUN)));
         slow_osc_en <= (state_r != S_PDOWN);
         crystal32k_en <= (HIGH_CLK_TYPE == `HCLK_FAST_RC_WITH_CRYSTAL32K) &&
            (state_r != S_PDOWN);
         fast_clk_gate <= (state_r == S_RUN || state_r == S_GREEN) &&
            !cur_slow_r && !switching_r && !high_osc_stop_r;
         slow_clk_gate <= (state_r == S_RUN || state_r == S_GREEN) &&
            cur_slow_r && !switching_r;
         cpu_clk_en <= (state_r == S_RUN) && !switching_r &&
            (cur_slow_r ? fcpu_tick : !high_osc_stop_r);
         cpu_run <= (state_r == S_RUN);
         timer_enable <= (state_r != S_PDOWN && state_r != S_WARM);
         irq_enable <= (state_r != S_PDOWN && state_r != S_WARM);
         serial_enable <= (state_r == S_RUN) && !cur_slow_r && !switching_r;
         ext_irq_req <= ext_irq_flag_r;
      end
   end

   // ****************************************************************
   // APB slave
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (psel && !penable) begin
         pready <= 1'b1;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         if (hit(paddr, `IDX_MODE_CTRL)) begin
            if (!pwrite) begin
               prdata <= {27'h0000000, green_request_r, sleep_request_r,
                  slow_clock_select_r, high_osc_stop_r, 1'b0};
            end
         end else if (hit(paddr, `IDX_RESUME_EN)) begin
            if (!pwrite) begin
               prdata <= {24'h000000, second_port_resume_enable_r};
            end
         end else if (hit(paddr, `IDX_STATUS)) begin
            if (!pwrite) begin
               prdata <= {26'h0000000, switching_r, cur_slow_r, state_r,
                  ext_irq_flag_r, wake_flag_r};
            end
         end else begin
            pslverr <= 1'b1;
         end
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

endmodule

/* opmode_checker_properties.sv */
`timescale 1ns/1ps
// ****
// Mode checker.
// ****
module opmode_checker (
   // Clock and reset.
   input wire pclk,
   input wire presetn,
   // Observed outputs.
   input wire fast_osc_en,
   input wire slow_osc_en,
   input wire crystal32k_en,
   input wire fast_clk_gate,
   input wire slow_clk_gate,
   input wire cpu_run,
   input wire timer_enable,
   input wire irq_enable,
   input wire serial_enable
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_reset_normal;
      $rose(presetn) |-> cpu_run && fast_clk_gate && !slow_clk_gate;
   endproperty
   a_reset_normal: assert property (p_reset_normal)
      else $error("not normal after reset");
   property p_gate_excl;
      !(fast_clk_gate && slow_clk_gate);
   endproperty
   a_gate_excl: assert property (p_gate_excl)
      else $error("both clock gates open");
   property p_switch_gap;
      $fell(fast_clk_gate) && cpu_run |-> !slow_clk_gate [*4];
   endproperty
   a_switch_gap: assert property (p_switch_gap)
      else $error("clock switch gap too short");
   property p_slow_keeps_fast;
      $rose(slow_clk_gate) |-> fast_osc_en;
   endproperty
   a_slow_keeps_fast: assert property (p_slow_keeps_fast)
      else $error("fast oscillator stopped on slow entry");
   property p_normal_osc;
      cpu_run && fast_clk_gate |-> fast_osc_en && slow_osc_en;
   endproperty
   a_normal_osc: assert property (p_normal_osc)
      else $error("oscillator off in normal mode");
   property p_pd_quiet;
      !slow_osc_en |-> !fast_osc_en && !crystal32k_en && !cpu_run && !timer_enable && !irq_enable;
   endproperty
   a_pd_quiet: assert property (p_pd_quiet)
      else $error("activity in power-down");
   property p_serial_idle;
      slow_clk_gate || !cpu_run |-> !serial_enable;
   endproperty
   a_serial_idle: assert property (p_serial_idle)
      else $error("serial enabled off normal mode");
   property p_wake_warm;
      $rose(slow_osc_en) |-> !cpu_run [*8] ##[20:40] (cpu_run && fast_clk_gate);
   endproperty
   a_wake_warm: assert property (p_wake_warm)
      else $error("bad resume after power-down");
endmodule
bind operating_mode_controller opmode_checker i_opmode_checker (.pclk, .presetn, .fast_osc_en,
   .slow_osc_en, .crystal32k_en, .fast_clk_gate, .slow_clk_gate, .cpu_run, .timer_enable,
   .irq_enable, .serial_enable);

/* wake_source_model.sv */
`timescale 1ns/1ps
// ****
// Wake pins and timer.
// ****
module wake_source_model (
   // Clock.
   input wire pclk,
   // Pins toward the controller.
   output logic [7:0] first_io_port,
   output logic [7:0] second_io_port,
   output logic ext_irq_pin,
   output logic timer_zero_overflow
);
   initial begin
      first_io_port = 8'h5A;
      second_io_port = 8'hA5;
      ext_irq_pin = 1'b0;
      timer_zero_overflow = 1'b0;
   end
   task automatic flip(input logic port, input int b);
      @(posedge pclk);
      if (port) second_io_port[b] <= ~second_io_port[b];
      else first_io_port[b] <= ~first_io_port[b];
   endtask
   task automatic tick();
      @(posedge pclk);
      timer_zero_overflow <= 1'b1;
      @(posedge pclk);
      timer_zero_overflow <= 1'b0;
   endtask
   task automatic irq_rise();
      @(posedge pclk);
      ext_irq_pin <= 1'b1;
   endtask
endmodule

/* operating_mode_controller_test.sv */
`timescale 1ns/1ps
`include "opmode_regs.vh"
// ****
// Bench top.
// ****
module operating_mode_controller_test;
   localparam logic [11:0] A_MODE = {2'h0, `IDX_MODE_CTRL, 2'h0};
   localparam logic [11:0] A_RES = {2'h0, `IDX_RESUME_EN, 2'h0};
   localparam logic [11:0] A_STAT = {2'h0, `IDX_STATUS, 2'h0};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] rdat;
   logic rerr;
   wire [31:0] prdata;
   wire [7:0] first_io_port, second_io_port;
   wire pready, pslverr, ext_irq_pin, timer_zero_overflow, fast_osc_en, slow_osc_en;
   wire crystal32k_en, fast_clk_gate, slow_clk_gate, cpu_clk_en, cpu_run;
   wire timer_enable, irq_enable, serial_enable, ext_irq_req;
   int err_total = 0;
   int n_tests = 0;
   int cyc = 0;
   operating_mode_controller #(.HIGH_CLK_TYPE(`HCLK_FAST_INTERNAL_RC), .LOW_FCPU_SEL(2'h2),
      .SLOW_RC_DIV(2))
      i_operating_mode_controller (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .first_io_port, .second_io_port, .ext_irq_pin,
      .timer_zero_overflow, .fast_osc_en, .slow_osc_en, .crystal32k_en, .fast_clk_gate,
      .slow_clk_gate, .cpu_clk_en, .cpu_run, .timer_enable, .irq_enable, .serial_enable,
      .ext_irq_req);
   wake_source_model i_wake_source_model (.pclk, .first_io_port, .second_io_port,
      .ext_irq_pin, .timer_zero_overflow);
   always #2 pclk = ~pclk;
   task automatic test_done();
      if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total = err_total + 1;
         test_done();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_run(input logic v);
      int i;
      for (i = 0; i < 300 && cpu_run !== v; i++) @(posedge pclk);
   endtask
   task automatic count_fcpu(input int cycles, output int n);
      n = 0;
      repeat (cycles) begin
         @(posedge pclk);
         if (cpu_clk_en === 1'b1) n++;
      end
   endtask
   task automatic t_reset();
      int n;
      apb(1'b0, A_MODE, 32'h0);
      chk("mode_ctrl", `MODE_CTRL_RESET, rdat);
      apb(1'b0, A_RES, 32'h0);
      chk("resume_en", `RESUME_EN_RESET, rdat);
      apb(1'b0, A_STAT, 32'h0);
      chk("status", 32'h0, rdat);
      chk("run_gates", 3'h6, {cpu_run, fast_clk_gate, slow_clk_gate});
      count_fcpu(8, n);
      chk("fast_fcpu", 32'h08, n);
      apb(1'b0, 12'h000, 32'h0);
      chk("unmapped", 2'h1, {rdat != 0, rerr});
   endtask
   task automatic t_slow_green();
      int n;
      apb(1'b1, A_MODE, 32'h04);
      repeat (12) @(posedge pclk);
      chk("slow_gates", 4'hB, {slow_clk_gate, fast_clk_gate, fast_osc_en, cpu_run});
      chk("serial_off", 1'b0, serial_enable);
      count_fcpu(24, n);
      chk("slow_fcpu", 32'h03, n);
      apb(1'b1, A_MODE, 32'h06);
      apb(1'b1, A_MODE, 32'h16);
      wait_run(1'b0);
      i_wake_source_model.tick();
      wait_run(1'b1);
      chk("green_back_slow", 2'h2, {slow_clk_gate, fast_osc_en});
      apb(1'b0, A_MODE, 32'h0);
      chk("green_cleared", 32'h06, rdat);
      apb(1'b0, A_STAT, 32'h0);
      chk("green_wake", 1'b1, rdat[0]);
   endtask
   task automatic t_sleep_port();
      apb(1'b1, A_STAT, 32'h01);
      apb(1'b1, A_MODE, 32'h0E);
      wait_run(1'b0);
      chk("pd_osc", 3'h0, {fast_osc_en, slow_osc_en, timer_enable});
      i_wake_source_model.flip(1'b1, 0);
      repeat (40) @(posedge pclk);
      chk("masked_pin", 1'b0, cpu_run);
      apb(1'b1, A_RES, 32'h01);
      i_wake_source_model.flip(1'b1, 0);
      wait_run(1'b1);
      chk("wake_normal", 2'h2, {fast_clk_gate, slow_clk_gate});
      apb(1'b0, A_MODE, 32'h0);
      chk("mode_cleared", 32'h0, rdat);
      apb(1'b0, A_STAT, 32'h0);
      chk("wake_flag", 1'b1, rdat[0]);
      apb(1'b1, A_STAT, 32'h01);
      apb(1'b0, A_STAT, 32'h0);
      chk("wake_clear", 1'b0, rdat[0]);
   endtask
   task automatic t_sleep_irq();
      apb(1'b1, A_MODE, 32'h02);
      wait_run(1'b0);
      chk("stop_pd", 1'b0, slow_osc_en);
      i_wake_source_model.irq_rise();
      wait_run(1'b1);
      apb(1'b0, A_STAT, 32'h0);
      chk("irq_flags", 3'h6, {ext_irq_req, rdat[1:0]});
      apb(1'b1, A_MODE, 32'h08);
      wait_run(1'b0);
      i_wake_source_model.flip(1'b0, 3);
      wait_run(1'b1);
      chk("first_port_wake", 1'b1, cpu_run);
   endtask
   task automatic t_rereset();
      apb(1'b1, A_MODE, 32'h04);
      repeat (12) @(posedge pclk);
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_slow_green();
      t_sleep_port();
      t_sleep_irq();
      t_rereset();
      test_done();
   end
endmodule
